/* spx_expander.sv */
`timescale 1ns/1ps
module spx_expander (
	input  wire logic                       core_clk_in,    // 250 MHz core clock
	input  wire logic                       reset_in,       // power-on reset, high
	input  wire logic                       rst_n_in,       // reset pin, low active
	input  wire logic                       addr_strap_in,  // address strap pin
	input  wire logic                       scl_in,         // serial clock line
	input  wire logic                       sda_in,         // serial data line level
	output logic                            sda_out,        // data drive value, always 0
	output logic                            sda_oe_n_out,   // low pulls data line low
	input  wire logic [spx_pkg::PORT_W-1:0] pins_in,        // port pin levels
	output logic      [spx_pkg::PORT_W-1:0] pins_out,       // port pin drive values
	output logic      [spx_pkg::PORT_W-1:0] pins_oe_n_out,  // low drives the pin
	output logic                            int_n_out,      // interrupt drive value, 0
	output logic                            int_oe_n_out    // low pulls interrupt low
);

	// synchronised lines and the single state record
	spx_pkg::spx_line_type  raw_lines;
	spx_pkg::spx_line_type  lines;
	spx_pkg::spx_state_type st_r;
	spx_pkg::spx_state_type st_nxt;
	spx_pkg::spx_state_type st_default;

	// decoded bus events and port views
	logic                        scl_rise;
	logic                        scl_fall;
	logic                        start_seen;
	logic                        stop_seen;
	logic                        addr_match;
	logic [spx_pkg::PORT_W-1:0]  input_view;
	logic [7:0]                  read_byte;
	logic [spx_pkg::PORT_W-1:0]  change_mask;
	logic                        int_pending;

	// all outside lines in one bundle
	// scl, sda, reset pin, strap and port pins travel together
	always_comb
	begin
		raw_lines            = '0;
		raw_lines.scl        = scl_in;
		raw_lines.sda        = sda_in;
		raw_lines.rst_n      = rst_n_in;
		raw_lines.addr_strap = addr_strap_in;
		raw_lines.pins       = pins_in;
	end

	// two flops before any logic sees them
	spx_sync #(
		.WIDTH    ($bits(spx_pkg::spx_line_type))
	) u_sync (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.async_in    (raw_lines),
		.sync_out    (lines)
	);

	// default contents of every register and the bus fsm
	always_comb
	begin
		st_default             = '0;
		st_default.bus_state   = spx_pkg::BUS_IDLE;
		st_default.bit_cnt     = spx_pkg::BIT_CNT_RST;
		st_default.shift       = spx_pkg::SHIFT_RST;
		st_default.rd_nwr      = 1'b0;
		st_default.master_nack = 1'b0;
		st_default.scl_q       = 1'b1;
		st_default.sda_q       = 1'b1;
		st_default.sda_oe_n    = 1'b1;
		st_default.cmd         = spx_pkg::CMD_RST;
		st_default.out_val     = spx_pkg::OUTPUT_RST;
		st_default.polar       = spx_pkg::POLAR_RST;
		st_default.dir         = spx_pkg::DIR_RST;
		// snapshot reloaded from the pins while settling
		st_default.snap        = '0;
		st_default.settle      = spx_pkg::SETTLE_CNT;  // snapshot reloads after reset
		st_default.int_oe_n    = 1'b1;
	end

	// edges and bus conditions from synchronised lines
	assign scl_rise   = lines.scl & ~st_r.scl_q;
	assign scl_fall   = ~lines.scl & st_r.scl_q;
	assign start_seen = lines.scl & st_r.scl_q & st_r.sda_q & ~lines.sda;
	assign stop_seen  = lines.scl & st_r.scl_q & ~st_r.sda_q & lines.sda;

	// address byte decode, bit 1 follows the strap
	// strap is read live, so it may change between frames
	assign addr_match = (st_r.shift[7:2] == spx_pkg::ADDR_FIXED)
		&& (st_r.shift[1] == lines.addr_strap);

	// input port as seen by the master, bit n is pin n
	assign input_view = lines.pins ^ st_r.polar;

	// byte returned for the current command
	// unknown commands read back as zero
	always_comb
	begin
		unique case (st_r.cmd)
			spx_pkg::CMD_INPUT:  read_byte = input_view;
			spx_pkg::CMD_OUTPUT: read_byte = st_r.out_val;
			spx_pkg::CMD_POLAR:  read_byte = st_r.polar;
			spx_pkg::CMD_DIR:    read_byte = st_r.dir;
			default:             read_byte = 8'h00;
		endcase
	end

	// change detect: only input-mode pins, against the snapshot
	// a pin turned from output to input may differ at once
	assign change_mask = (lines.pins ^ st_r.snap) & st_r.dir;
	assign int_pending = |change_mask;

	// next state of bus fsm, registers and interrupt
	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.scl_q = lines.scl;
		st_nxt.sda_q = lines.sda;

		// bus slave, byte level
		// stop releases the line and idles the slave
		if (stop_seen)
		begin
			st_nxt.bus_state = spx_pkg::BUS_IDLE;
			st_nxt.sda_oe_n  = 1'b1;
		end
		else if (start_seen)
		begin
			// start or repeated start at any point restarts address phase
			st_nxt.bus_state = spx_pkg::BUS_ADDR;
			st_nxt.bit_cnt   = spx_pkg::BIT_CNT_RST;
			st_nxt.sda_oe_n  = 1'b1;
		end
		else
		begin
			unique case (st_r.bus_state)
				spx_pkg::BUS_IDLE,
				spx_pkg::BUS_WAIT_STOP:
				begin
					st_nxt.sda_oe_n = 1'b1;  // foreign traffic is ignored
				end

				spx_pkg::BUS_ADDR,
				spx_pkg::BUS_CMD,
				spx_pkg::BUS_WDATA:
				begin
					// sample on clock rise, msb first
					if (scl_rise)
					begin
						st_nxt.shift   = {st_r.shift[6:0], lines.sda};
						st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
					end
					// eighth bit taken: ack decided on the falling edge
					else if (scl_fall && st_r.bit_cnt == spx_pkg::BITS_PER_BYTE)
					begin
						st_nxt.bit_cnt = spx_pkg::BIT_CNT_RST;
						if (st_r.bus_state == spx_pkg::BUS_ADDR)
						begin
							if (addr_match)
							begin
								st_nxt.rd_nwr    = st_r.shift[0];
								st_nxt.sda_oe_n  = 1'b0;
								st_nxt.bus_state = spx_pkg::BUS_ADDR_ACK;
							end
							else
							begin
								st_nxt.bus_state = spx_pkg::BUS_WAIT_STOP;
							end
						end
						else if (st_r.bus_state == spx_pkg::BUS_CMD)
						begin
							st_nxt.cmd       = st_r.shift;
							st_nxt.sda_oe_n  = 1'b0;
							st_nxt.bus_state = spx_pkg::BUS_CMD_ACK;
						end
						else
						begin
							// store data; input port ignores writes
							// every data byte is acked, read-only or unknown alike
							unique case (st_r.cmd)
								spx_pkg::CMD_OUTPUT: st_nxt.out_val = st_r.shift;
								spx_pkg::CMD_POLAR:  st_nxt.polar   = st_r.shift;
								spx_pkg::CMD_DIR:    st_nxt.dir     = st_r.shift;
								default:             st_nxt.out_val = st_r.out_val;
							endcase
							st_nxt.sda_oe_n  = 1'b0;
							st_nxt.bus_state = spx_pkg::BUS_WDATA_ACK;
						end
					end
				end

				spx_pkg::BUS_ADDR_ACK:
				begin
					// release ack, then send or receive
					// first data bit goes out while the clock is low
					if (scl_fall)
					begin
						if (st_r.rd_nwr)
						begin
							st_nxt.shift     = read_byte;
							st_nxt.sda_oe_n  = read_byte[7];
							st_nxt.bit_cnt   = 4'h1;
							st_nxt.bus_state = spx_pkg::BUS_RDATA;
						end
						else
						begin
							st_nxt.sda_oe_n  = 1'b1;
							st_nxt.bus_state = spx_pkg::BUS_CMD;
						end
					end
				end

				spx_pkg::BUS_CMD_ACK,
				spx_pkg::BUS_WDATA_ACK:
				begin
					// more data bytes may follow until stop
					// no auto-increment: the command stays for later bytes
					if (scl_fall)
					begin
						st_nxt.sda_oe_n  = 1'b1;
						st_nxt.bus_state = spx_pkg::BUS_WDATA;
					end
				end

				spx_pkg::BUS_RDATA:
				begin
					// shift out on clock fall, msb first
					if (scl_fall)
					begin
						if (st_r.bit_cnt == spx_pkg::BITS_PER_BYTE)
						begin
							st_nxt.sda_oe_n  = 1'b1;
							st_nxt.bit_cnt   = spx_pkg::BIT_CNT_RST;
							st_nxt.bus_state = spx_pkg::BUS_RDATA_ACK;
						end
						else
						begin
							st_nxt.sda_oe_n = st_r.shift[6];
							st_nxt.shift    = {st_r.shift[6:0], 1'b0};
							st_nxt.bit_cnt  = st_r.bit_cnt + 4'h1;
						end
					end
				end

				// master's ack or nack taken on the clock rise
				spx_pkg::BUS_RDATA_ACK:
				begin
					if (scl_rise)
					begin
						st_nxt.master_nack = lines.sda;
						// port read: snapshot follows the pins, pending cleared
						if (st_r.cmd == spx_pkg::CMD_INPUT)
							st_nxt.snap = lines.pins;
					end
					// nack ends the read, ack reloads the same register
					else if (scl_fall)
					begin
						if (st_r.master_nack)
						begin
							st_nxt.bus_state = spx_pkg::BUS_WAIT_STOP;
						end
						else
						begin
							st_nxt.shift     = read_byte;
							st_nxt.sda_oe_n  = read_byte[7];
							st_nxt.bit_cnt   = 4'h1;
							st_nxt.bus_state = spx_pkg::BUS_RDATA;
						end
					end
				end

				// unused state codes fall back to idle
				default:
				begin
					st_nxt.bus_state = spx_pkg::BUS_IDLE;
					st_nxt.sda_oe_n  = 1'b1;
				end
			endcase
		end

		// snapshot taken while synchronised pins settle after reset
		// keeps the first compare off the synchroniser's reset ones
		if (st_r.settle != 2'h0)
		begin
			st_nxt.settle   = st_r.settle - 2'h1;
			st_nxt.snap     = lines.pins;
			st_nxt.int_oe_n = 1'b1;
		end
		else
		begin
			st_nxt.int_oe_n = ~int_pending;
		end

		// reset pin forces every default while low
		// overrides all above, so a cut frame leaves nothing behind
		if (!lines.rst_n)
			st_nxt = st_default;
	end

	// single state register
	// power-on reset takes the same defaults as the reset pin
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			st_r <= st_default;
		else
			st_r <= st_nxt;
	end

	// outputs straight from the state register
	// open-drain lines: drive value fixed at zero, enable does the work
	assign sda_out       = 1'b0;
	assign sda_oe_n_out  = st_r.sda_oe_n;
	assign pins_out      = st_r.out_val;
	assign pins_oe_n_out = st_r.dir;
	assign int_n_out     = 1'b0;
	assign int_oe_n_out  = st_r.int_oe_n;

endmodule // spx_expander

/* spx_expander_monitor.sv */
`timescale 1ns/1ps
module spx_expander_monitor (
	input wire logic       core_clk_in,   // core clock
	input wire logic       reset_in,      // power-on reset
	input wire logic       rst_n_in,      // reset pin
	input wire logic       scl_in,        // serial clock
	input wire logic [7:0] pins_in,       // pin levels
	input wire logic       sda_out,       // data drive value
	input wire logic       sda_oe_n_out,  // data pull low
	input wire logic [7:0] pins_out,      // output register
	input wire logic [7:0] pins_oe_n_out, // direction
	input wire logic       int_n_out,     // interrupt drive value
	input wire logic       int_oe_n_out   // interrupt pull low
);
	logic dflt;
	// every output at its reset value
	assign dflt = pins_out == 8'hff && pins_oe_n_out == 8'hff && int_oe_n_out && sda_oe_n_out;
	default clocking cb @(posedge core_clk_in); endclocking

	// open drain lines only ever pull low
	property p_sda_zero;
		sda_out == 1'b0;
	endproperty
	a_sda_zero: assert property (p_sda_zero) else $error("data drive not zero");
	property p_int_zero;
		int_n_out == 1'b0;
	endproperty
	a_int_zero: assert property (p_int_zero) else $error("irq drive not zero");
	// both resets give defaults
	property p_por;
		reset_in |=> dflt;
	endproperty
	a_por: assert property (p_por) else $error("no defaults after reset");
	property p_pin_rst;
		disable iff (reset_in) $fell(rst_n_in) ##1 (!rst_n_in)[*3] |=> dflt;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("no defaults under pin reset");
	// no new pull low while the clock is high
	property p_no_pull_high;
		disable iff (reset_in) scl_in[*6] |-> !$fell(sda_oe_n_out);
	endproperty
	a_no_pull_high: assert property (p_no_pull_high) else $error("data pulled in high clock");
	// registers update only in the low clock phase
	property p_cfg_low;
		disable iff (reset_in || !rst_n_in) $changed(pins_out) || $changed(pins_oe_n_out) |-> !scl_in;
	endproperty
	a_cfg_low: assert property (p_cfg_low) else $error("register update in high clock");
	// an input edge pulls the line low within six cycles
	property p_int_raise;
		disable iff (reset_in || !rst_n_in)
		($stable(pins_in) && $stable(pins_oe_n_out))[*8] ##1
		($changed(pins_in & pins_oe_n_out) && $stable(pins_oe_n_out) && int_oe_n_out)
		|-> ##[2:6] !int_oe_n_out;
	endproperty
	a_int_raise: assert property (p_int_raise) else $error("input edge gave no irq");
	// quiet inputs keep a released line released
	property p_int_hold;
		disable iff (reset_in || !rst_n_in)
		($stable(pins_in & pins_oe_n_out) && $stable(pins_oe_n_out))[*6] ##0 int_oe_n_out
		|=> int_oe_n_out;
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("irq without input edge");
endmodule // spx_expander_monitor

bind spx_expander spx_expander_monitor i_spx_expander_monitor (
	.core_clk_in(core_clk_in), .reset_in(reset_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
	.pins_in(pins_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .pins_out(pins_out),
	.pins_oe_n_out(pins_oe_n_out), .int_n_out(int_n_out), .int_oe_n_out(int_oe_n_out)
);

/* spx_expander_tb.sv */
`timescale 1ns/1ps
module spx_expander_tb;
	logic       core_clk_in, reset_in, rst_n_in, scl, sda_low, sda_oe_n, int_oe_n, strap;
	logic [7:0] ext, out_v, pins_in, pins_out, pins_oe_n, addr_w;
	wire        sda;
	int         fails = 0;
	int         checks = 0;

	// pulled-up data line and port pins resolved from all drivers
	assign addr_w = {spx_pkg::ADDR_FIXED, strap, 1'b0};
	assign sda = !(sda_low || !sda_oe_n);
	assign pins_in = (pins_oe_n & ext) | (~pins_oe_n & pins_out);

	spx_expander i_spx_expander (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.rst_n_in(rst_n_in), .addr_strap_in(strap), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe_n_out(sda_oe_n), .pins_in(pins_in), .pins_out(pins_out),
		.pins_oe_n_out(pins_oe_n), .int_n_out(), .int_oe_n_out(int_oe_n));
	spx_master i_spx_master (.core_clk_in(core_clk_in), .sda_in(sda), .scl_out(scl),
		.sda_low_out(sda_low));

	initial
	begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask
	// one register write, each byte acknowledged
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		logic [8:0] q;
		i_spx_master.start();
		i_spx_master.xfer({addr_w, 1'b1}, q);
		check(q[0], 1'b0);
		i_spx_master.xfer({cmd, 1'b1}, q);
		check(q[0], 1'b0);
		i_spx_master.xfer({d, 1'b1}, q);
		check(q[0], 1'b0);
		i_spx_master.stop();
		cyc(8);
	endtask
	// set pointer, restart, read two bytes, master ack then nack
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		logic [8:0] q;
		i_spx_master.start();
		i_spx_master.xfer({addr_w, 1'b1}, q);
		i_spx_master.xfer({cmd, 1'b1}, q);
		i_spx_master.start();
		i_spx_master.xfer({addr_w | 8'h01, 1'b1}, q);
		check(q[0], 1'b0);
		i_spx_master.xfer(9'h1fe, q);
		check(q[8:1], exp);
		i_spx_master.xfer(9'h1ff, q);
		check(q[8:1], exp);
		i_spx_master.stop();
		cyc(8);
	endtask
	// register set: write, read back, input port view
	task automatic t_regs();
		check({pins_out, int_oe_n}, {8'hff, 1'b1});
		check(pins_oe_n, 8'hff);
		wr(spx_pkg::CMD_OUTPUT, out_v);
		check(pins_out, out_v);
		wr(spx_pkg::CMD_DIR, 8'h0f);
		check(pins_oe_n, 8'h0f);
		wr(spx_pkg::CMD_POLAR, 8'hf0);
		wr(spx_pkg::CMD_INPUT, 8'h00);
		wr(8'h07, 8'h55);
		rd(spx_pkg::CMD_OUTPUT, out_v);
		rd(spx_pkg::CMD_POLAR, 8'hf0);
		rd(spx_pkg::CMD_DIR, 8'h0f);
		rd(8'h07, 8'h00);
		rd(spx_pkg::CMD_INPUT, {out_v[7:4], ext[3:0]} ^ 8'hf0);
	endtask
	// change detection, withdrawal, clear by read, other slave, outputs
	task automatic t_int();
		logic [8:0] q;
		ext[0] = ~ext[0];
		cyc(8);
		check(int_oe_n, 1'b0);
		ext[0] = ~ext[0];
		cyc(8);
		check(int_oe_n, 1'b1);
		ext[1] = ~ext[1];
		cyc(8);
		check(int_oe_n, 1'b0);
		i_spx_master.start();
		i_spx_master.xfer({spx_pkg::ADDR_FIXED, ~strap, 2'b11}, q);
		check(q[0], 1'b1);
		i_spx_master.stop();
		check(int_oe_n, 1'b0);
		rd(spx_pkg::CMD_INPUT, {out_v[7:4], ext[3:0]} ^ 8'hf0);
		check(int_oe_n, 1'b1);
		ext[2] = ~ext[2];
		cyc(8);
		check(int_oe_n, 1'b0);
		rd(spx_pkg::CMD_INPUT, {out_v[7:4], ext[3:0]} ^ 8'hf0);
		out_v = 8'ha5;
		wr(spx_pkg::CMD_OUTPUT, out_v);
		check(int_oe_n, 1'b1);
	endtask
	// reset pin restores defaults, bus usable at once
	task automatic t_pin_reset();
		rst_n_in = 1'b0;
		cyc(8);
		rst_n_in = 1'b1;
		cyc(8);
		check({pins_out, pins_oe_n}, 16'hffff);
		rd(spx_pkg::CMD_POLAR, 8'h00);
	endtask
	// strap low moves the address, old address no longer answered
	task automatic t_strap();
		logic [8:0] q;
		strap = 1'b0;
		cyc(8);
		i_spx_master.start();
		i_spx_master.xfer({spx_pkg::ADDR_FIXED, 2'b11, 1'b1}, q);
		check(q[0], 1'b1);
		i_spx_master.stop();
		cyc(8);
		rd(spx_pkg::CMD_DIR, 8'hff);
	endtask

	initial
	begin
		reset_in = 1'b1;
		rst_n_in = 1'b1;
		strap = 1'b1;
		ext = 8'h3c;
		out_v = 8'h5a;
		cyc(16);
		reset_in = 1'b0;
		cyc(8);
		t_regs();
		t_int();
		t_pin_reset();
		t_strap();
		test_done();
	end
	// hang guard, a few times the expected run
	initial
	begin
		#300000;
		fails++;
		test_done();
	end
endmodule // spx_expander_tb

/* spx_master.sv */
`timescale 1ns/1ps
module spx_master (
	input  wire logic core_clk_in, // core clock
	input  wire logic sda_in,      // resolved data line
	output logic      scl_out,     // serial clock, idle high
	output logic      sda_low_out  // high pulls data low
);
	// quarter bit time, 32 ns
	task automatic qtr();
		repeat (8) @(negedge core_clk_in);
	endtask
	// start or repeated start from idle or held bus
	task automatic start();
		sda_low_out = 1'b0;
		qtr();
		scl_out = 1'b1;
		qtr();
		sda_low_out = 1'b1;
		qtr();
		scl_out = 1'b0;
		qtr();
	endtask
	// stop, leaves both lines released
	task automatic stop();
		sda_low_out = 1'b1;
		qtr();
		scl_out = 1'b1;
		qtr();
		sda_low_out = 1'b0;
		qtr();
	endtask
	// byte msb first plus acknowledge slot, data moves only with clock low
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			sda_low_out = ~d[i];
			qtr();
			scl_out = 1'b1;
			qtr();
			q[i] = sda_in;
			qtr();
			scl_out = 1'b0;
			qtr();
		end
	endtask
	// idle bus
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
endmodule // spx_master

/* spx_pkg.sv */
package spx_pkg;

	// port geometry
	localparam int          PORT_W      = 8;
	localparam int          SYNC_STAGES = 2;

	// slave address: fixed upper six bits, then strap bit, then read flag
	localparam logic [5:0]  ADDR_FIXED  = 6'h10;

	// command byte codes selecting the target register
	localparam logic [7:0]  CMD_INPUT   = 8'h00;
	localparam logic [7:0]  CMD_OUTPUT  = 8'h01;
	localparam logic [7:0]  CMD_POLAR   = 8'h02;
	localparam logic [7:0]  CMD_DIR     = 8'h03;

	// values after reset
	localparam logic [7:0]  CMD_RST     = 8'h00;
	localparam logic [7:0]  OUTPUT_RST  = 8'hff;
	localparam logic [7:0]  POLAR_RST   = 8'h00;
	localparam logic [7:0]  DIR_RST     = 8'hff;
	localparam logic [7:0]  SHIFT_RST   = 8'h00;

	// bit counts and settle counts
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [3:0]  BIT_CNT_RST   = 4'h0;
	localparam logic [1:0]  SETTLE_CNT    = 2'h3;

	// raw lines from outside the clock domain, one bundle through the synchroniser
	typedef struct packed {
		logic                scl;
		logic                sda;
		logic                rst_n;
		logic                addr_strap;
		logic [PORT_W-1:0]   pins;
	} spx_line_type;

	// serial bus slave states
	typedef enum logic [3:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ADDR_ACK,
		BUS_CMD,
		BUS_CMD_ACK,
		BUS_WDATA,
		BUS_WDATA_ACK,
		BUS_RDATA,
		BUS_RDATA_ACK,
		BUS_WAIT_STOP
	} spx_bus_state_type;

	// complete state of the expander core
	typedef struct packed {
		spx_bus_state_type   bus_state;
		logic [3:0]          bit_cnt;
		logic [7:0]          shift;
		logic                rd_nwr;
		logic                master_nack;
		logic                scl_q;
		logic                sda_q;
		logic                sda_oe_n;
		logic [7:0]          cmd;
		logic [PORT_W-1:0]   out_val;
		logic [PORT_W-1:0]   polar;
		logic [PORT_W-1:0]   dir;
		logic [PORT_W-1:0]   snap;
		logic [1:0]          settle;
		logic                int_oe_n;
	} spx_state_type;

endpackage

/* spx_sync.sv */
`timescale 1ns/1ps
module spx_sync #(
	parameter int WIDTH = 12
) (
	input  wire logic             core_clk_in,  // core clock
	input  wire logic             reset_in,     // synchronous reset, high
	input  wire logic [WIDTH-1:0] async_in,     // lines from another domain
	output logic      [WIDTH-1:0] sync_out      // lines after two flops
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} spx_sync_state_type;

	spx_sync_state_type st_r;
	spx_sync_state_type st_nxt;

	// first stage feeds only the second
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.stage1 = async_in;
		st_nxt.stage2 = st_r.stage1;
	end

	// idle level is high for bus lines and reset pin
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			st_r <= '{stage1: '1, stage2: '1};
		else
			st_r <= st_nxt;
	end

	assign sync_out = st_r.stage2;

endmodule // spx_sync
